// ### include/ffmt_map.vh
`ifndef FFMT_MAP_VH
`define FFMT_MAP_VH
// register byte addresses on the internal register port
`define FFMT_ADDR_CFG 8'h15
`define FFMT_ADDR_SRC 8'h16
`define FFMT_ADDR_THS 8'h17
`define FFMT_ADDR_THS_X_MSB 8'h73
`define FFMT_ADDR_THS_X_LSB 8'h74
`define FFMT_ADDR_THS_Y_MSB 8'h75
`define FFMT_ADDR_THS_Y_LSB 8'h76
`define FFMT_ADDR_THS_Z_MSB 8'h77
`define FFMT_ADDR_THS_Z_LSB 8'h78
`define FFMT_ADDR_COUNT 8'h18
// configuration register fields
`define FFMT_CFG_LATCH 7
`define FFMT_CFG_HIGHG 6
`define FFMT_CFG_ZEN 5
`define FFMT_CFG_YEN 4
`define FFMT_CFG_XEN 3
// common threshold register fields
`define FFMT_THS_DBMODE 7
// per-axis threshold msb register: enable bit sits in x msb
`define FFMT_THSX_AXIS_EN 7
// source register fields
`define FFMT_SRC_ACTIVE 7
`define FFMT_SRC_ZHIT 5
`define FFMT_SRC_ZNEG 4
`define FFMT_SRC_YHIT 3
`define FFMT_SRC_YNEG 2
`define FFMT_SRC_XHIT 1
`define FFMT_SRC_XNEG 0
// reset values
`define FFMT_RST_BYTE 8'h00
`endif

// ### core/axis_compare.v
// one axis: magnitude of a 14-bit two's complement sample against a 13-bit threshold
module axis_compare (
  // sample and threshold
  input wire [13:0] sample,
  input wire [12:0] threshold,
  // results
  output wire above,
  output wire below,
  output wire negative
);
  wire [13:0] magnitude;
  // most negative code reads as 2000h, still above the largest 13-bit threshold
  assign magnitude = sample[13] ? (14'h0000 - sample) : sample;
  assign above = magnitude > {1'b0, threshold};
  assign below = magnitude < {1'b0, threshold};
  assign negative = sample[13];
endmodule

// ### core/freefall_motion_detector.v
// How it works
// R1: mode bit selects low-g or high-g
// R2: low-g needs all enabled axes
// R3: high-g needs any enabled axis
// R4: common threshold 17h, per-axis 73h-78h
// R5: latch bit set latches the event
// R6: latched flag cleared only by source read
// R7: unlatched flag follows current detection
// R8: per-axis enables gate axis participation
// R9: common 7-bit unsigned threshold when off
// R10: per-axis 13-bit thresholds when on
// R11: free-fall is below threshold for duration
// R12: motion is above threshold for duration
// R13: debounce counter sets required sample count
// R14: debounce mode bit in threshold register
// R15: source keeps per-axis hit and sign
// R16: mode 0 decrements, mode 1 clears
// R17: absolute value compared once per sample
// R18: configuration 15h, source 16h
`include "ffmt_map.vh"
module freefall_motion_detector #(
  parameter SAMPLE_WIDTH = 14
) (
  // clock and reset
  input wire clk_sys,
  input wire arst_n,
  // acceleration samples, one per output data sample
  input wire sample_valid,
  input wire [SAMPLE_WIDTH-1:0] sample_x,
  input wire [SAMPLE_WIDTH-1:0] sample_y,
  input wire [SAMPLE_WIDTH-1:0] sample_z,
  // internal register port
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // event output
  output wire event_active_flag
);
  // configuration and threshold registers
  reg [7:0] cfg;
  reg [7:0] ths_common;
  reg [7:0] debounce_count_limit;
  reg [7:0] ths_msb [0:2];
  reg [7:0] ths_lsb [0:2];
  // debounce state, latched source bits and their next values
  reg [7:0] debounce_count;
  reg active;
  reg [5:0] axis_info;
  reg next_active;
  reg [5:0] next_source_axes;
  reg [7:0] next_rdata;
  // per-axis comparator view
  wire [SAMPLE_WIDTH-1:0] samples [0:2];
  wire [2:0] above;
  wire [2:0] below;
  wire [2:0] negative;
  // decoded configuration and combinational results
  wire [2:0] axis_en;
  wire axis_mode;
  wire high_g;
  wire condition;
  wire debounced;
  wire [7:0] next_count;
  wire [5:0] next_axis_info;
  wire source_read;
  wire [7:0] source_byte;

  assign samples[0] = sample_x;
  assign samples[1] = sample_y;
  assign samples[2] = sample_z;
  assign axis_en = {cfg[`FFMT_CFG_ZEN], cfg[`FFMT_CFG_YEN], cfg[`FFMT_CFG_XEN]}; // [R8]
  assign high_g = cfg[`FFMT_CFG_HIGHG]; // [R1]
  assign axis_mode = ths_msb[0][`FFMT_THSX_AXIS_EN];

  // one comparator per axis, threshold chosen by the per-axis enable
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : axis
      wire [12:0] thr;
      // common 7-bit value is aligned to the top of the 13-bit scale
      assign thr = axis_mode ? {ths_msb[g][4:0], ths_lsb[g]} // [R10]
                             : {ths_common[6:0], 6'h00};     // [R9]
      axis_compare cmp (
        .sample(samples[g][SAMPLE_WIDTH-1:SAMPLE_WIDTH-14]),
        .threshold(thr),
        .above(above[g]),
        .below(below[g]),
        .negative(negative[g])
      ); // [R17]
    end
  endgenerate

  // and across enabled axes for free-fall, or across them for motion
  function combine_axes;
    input [2:0] hit_above;
    input [2:0] hit_below;
    input [2:0] enable;
    input motion_mode;
    begin
      if (enable == 3'h0) begin
        combine_axes = 1'b0; // no axis enabled never raises an event
      end else if (motion_mode) begin
        combine_axes = |(hit_above & enable); // [R3] [R12]
      end else begin
        combine_axes = &(hit_below | ~enable); // [R2] [R11]
      end
    end
  endfunction

  // one debounce step; the counter saturates at the limit so it cannot wrap
  function [7:0] debounce_step;
    input [7:0] count;
    input [7:0] limit;
    input hit;
    input clear_on_miss;
    begin
      if (hit) begin
        debounce_step = (count < limit) ? count + 8'h01 : count;
      end else if (clear_on_miss) begin
        debounce_step = 8'h00; // [R16] [R14]
      end else if (count != 8'h00) begin
        debounce_step = count - 8'h01; // [R16]
      end else begin
        debounce_step = 8'h00;
      end
    end
  endfunction

  assign condition = combine_axes(above, below, axis_en, high_g);

  // decrementing mode forgives a single noisy sample, clearing mode does not
  assign next_count = debounce_step(debounce_count, debounce_count_limit, condition,
                                    ths_common[`FFMT_THS_DBMODE]);
  assign debounced = condition && (next_count >= debounce_count_limit); // [R13]

  // per-axis hit and sign; hits only count on enabled axes
  generate
    for (g = 0; g < 3; g = g + 1) begin : info
      assign next_axis_info[2*g+1] = above[g] & axis_en[g];
      assign next_axis_info[2*g] = negative[g];
    end
  endgenerate

  assign source_read = reg_read && (reg_addr == `FFMT_ADDR_SRC);
  assign source_byte = {active, 1'b0, axis_info};
  assign event_active_flag = active;

  // register writes
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= `FFMT_RST_BYTE;
      ths_common <= `FFMT_RST_BYTE;
      debounce_count_limit <= `FFMT_RST_BYTE;
      ths_msb[0] <= `FFMT_RST_BYTE;
      ths_msb[1] <= `FFMT_RST_BYTE;
      ths_msb[2] <= `FFMT_RST_BYTE;
      ths_lsb[0] <= `FFMT_RST_BYTE;
      ths_lsb[1] <= `FFMT_RST_BYTE;
      ths_lsb[2] <= `FFMT_RST_BYTE;
    end else if (reg_write) begin
      case (reg_addr)
        `FFMT_ADDR_CFG: cfg <= reg_wdata; // [R18]
        `FFMT_ADDR_THS: ths_common <= reg_wdata; // [R4]
        `FFMT_ADDR_COUNT: debounce_count_limit <= reg_wdata;
        `FFMT_ADDR_THS_X_MSB: ths_msb[0] <= reg_wdata; // [R4]
        `FFMT_ADDR_THS_X_LSB: ths_lsb[0] <= reg_wdata;
        `FFMT_ADDR_THS_Y_MSB: ths_msb[1] <= {3'h0, reg_wdata[4:0]};
        `FFMT_ADDR_THS_Y_LSB: ths_lsb[1] <= reg_wdata;
        `FFMT_ADDR_THS_Z_MSB: ths_msb[2] <= {3'h0, reg_wdata[4:0]};
        `FFMT_ADDR_THS_Z_LSB: ths_lsb[2] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // event flag next state; a new event beats a read in the same cycle
  always @* begin
    next_active = active;
    next_source_axes = axis_info;
    if (cfg[`FFMT_CFG_LATCH]) begin
      if (sample_valid && debounced) begin
        next_active = 1'b1; // [R5]
        next_source_axes = next_axis_info; // [R15]
      end else if (source_read) begin
        next_active = 1'b0; // [R6]
        next_source_axes = 6'h00;
      end
    end else if (sample_valid) begin
      next_active = debounced; // [R7]
      next_source_axes = debounced ? next_axis_info : 6'h00; // [R15]
    end
  end

  // debounce counter only moves on a sample; flag and source bits register here
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      debounce_count <= `FFMT_RST_BYTE;
      active <= 1'b0;
      axis_info <= 6'h00;
    end else begin
      if (sample_valid) begin
        debounce_count <= next_count;
      end
      active <= next_active;
      axis_info <= next_source_axes;
    end
  end

  // read mux; unmapped addresses answer zero so software never sees a stale byte
  always @* begin
    case (reg_addr)
      `FFMT_ADDR_CFG: next_rdata = cfg;
      `FFMT_ADDR_SRC: next_rdata = source_byte; // [R18]
      `FFMT_ADDR_THS: next_rdata = ths_common;
      `FFMT_ADDR_COUNT: next_rdata = debounce_count_limit;
      `FFMT_ADDR_THS_X_MSB: next_rdata = ths_msb[0];
      `FFMT_ADDR_THS_X_LSB: next_rdata = ths_lsb[0];
      `FFMT_ADDR_THS_Y_MSB: next_rdata = ths_msb[1];
      `FFMT_ADDR_THS_Y_LSB: next_rdata = ths_lsb[1];
      `FFMT_ADDR_THS_Z_MSB: next_rdata = ths_msb[2];
      `FFMT_ADDR_THS_Z_LSB: next_rdata = ths_lsb[2];
      default: next_rdata = 8'h00;
    endcase
  end

  // read data, registered one cycle after the read strobe and held until the next read
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `FFMT_RST_BYTE;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end
endmodule

// ### testbench/ffmt_checker_sva.sv
module ffmt_checker (
  // watched ports of the detector
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sample_valid,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic event_active_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic latch;
  wire src_rd = reg_read && reg_addr == 8'h16;
  // shadow of the latch bit, so latched checks stay quiet in real-time mode
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n) latch <= 1'b0;
    else if (reg_write && reg_addr == 8'h15) latch <= reg_wdata[7];
  property p_src; src_rd && !sample_valid |=> reg_rdata[7] == $past(event_active_flag); endproperty
  a_src: assert property (p_src) else $error("active bit misread");
  property p_rose; $rose(event_active_flag) |-> $past(sample_valid); endproperty
  a_rose: assert property (p_rose) else $error("flag set without sample");
  property p_quiet; !sample_valid && !src_rd |=> $stable(event_active_flag); endproperty
  a_quiet: assert property (p_quiet) else $error("flag moved unprompted");
  property p_unmap; reg_read && reg_addr == 8'h20 |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ths; reg_write && reg_addr == 8'h17 ##1 reg_read && reg_addr == 8'h17
    |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_ths: assert property (p_ths) else $error("threshold readback");
  property p_clr; latch && src_rd && !sample_valid |=> !event_active_flag; endproperty
  a_clr: assert property (p_clr) else $error("source read kept flag");
  property p_keep; latch && event_active_flag && !src_rd |=> event_active_flag; endproperty
  a_keep: assert property (p_keep) else $error("latched flag dropped");
  property p_hold; !reg_read |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind freefall_motion_detector ffmt_checker chk (.clk_sys, .arst_n, .sample_valid, .reg_write,
  .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .event_active_flag);

// ### testbench/host_model.sv
module host_model (
  // clock
  input wire logic clk_sys,
  // requests to the detector
  output logic reg_write,
  output logic reg_read,
  output logic sample_valid,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic [13:0] sample_x,
  output logic [13:0] sample_y,
  output logic [13:0] sample_z
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {reg_write, reg_read, sample_valid, reg_addr, reg_wdata,
           sample_x, sample_y, sample_z} = '0;
  // one request per call, held over the taking edge; idle sample lines toggle
  task op(input logic [2:0] s, input logic [7:0] a, d, input logic [13:0] x, y, z);
    {reg_write, reg_read, sample_valid, reg_addr, reg_wdata} = {s, a, d};
    sample_x = s[0] ? x : ~sample_x;
    sample_y = s[0] ? y : ~sample_y;
    sample_z = s[0] ? z : ~sample_z;
    @(posedge clk_sys);
    #1;
  endtask
endmodule

// ### testbench/tb_freefall_motion_detector.sv
module tb_freefall_motion_detector;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  int fail_count = 0;
  int checked = 0;
  wire reg_write, reg_read, sample_valid, event_active_flag;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire [13:0] sample_x, sample_y, sample_z;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
  initial forever #5 clk_sys = ~clk_sys;
  host_model host (.clk_sys, .reg_write, .reg_read, .sample_valid, .reg_addr, .reg_wdata,
    .sample_x, .sample_y, .sample_z);
  freefall_motion_detector uut (.clk_sys, .arst_n, .sample_valid, .sample_x, .sample_y,
    .sample_z, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
    .event_active_flag);
  // register and sample helpers
  task wr(input logic [7:0] a, d);
    host.op(3'b100, a, d, 14'h0000, 14'h0000, 14'h0000);
  endtask
  task rchk(input logic [7:0] a, e);
    host.op(3'b010, a, 8'h00, 14'h0000, 14'h0000, 14'h0000);
    `CHK(reg_rdata, e)
  endtask
  task sfz(input logic [13:0] x, y, z, input logic e);
    host.op(3'b001, 8'h00, 8'h00, x, y, z);
    `CHK(event_active_flag, e)
  endtask
  task sf(input logic [13:0] x, y, input logic e);
    sfz(x, y, 14'h0000, e);
  endtask
  task end_sim;
    $display("mismatches %0d checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog well beyond the roughly 56 cycles of the run
  initial begin
    #5000;
    fail_count++;
    end_sim();
  end
  // common threshold 10h scales to 400h on the sample scale
  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    rchk(8'h15, 8'h00);
    rchk(8'h16, 8'h00);
    wr(8'h17, 8'h10);
    rchk(8'h17, 8'h10);
    wr(8'h15, 8'h58);
    sf(14'h0500, 14'h0000, 1'b1);
    rchk(8'h16, 8'h82);
    sf(14'h3b00, 14'h0000, 1'b1);
    rchk(8'h16, 8'h83);
    wr(8'h15, 8'h48);
    sf(14'h0400, 14'h1fff, 1'b0);
    wr(8'h15, 8'hd8);
    sf(14'h0500, 14'h0000, 1'b1);
    sf(14'h0000, 14'h0000, 1'b1);
    wr(8'h20, 8'hff);
    rchk(8'h20, 8'h00);
    rchk(8'h16, 8'h82);
    `CHK(event_active_flag, 1'b0)
    wr(8'h15, 8'h18);
    sf(14'h0100, 14'h1000, 1'b0);
    sf(14'h0100, 14'h3f00, 1'b1);
    wr(8'h73, 8'h80);
    wr(8'h74, 8'h40);
    wr(8'h15, 8'h58);
    sf(14'h0041, 14'h0000, 1'b1);
    sf(14'h0040, 14'h0000, 1'b0);
    wr(8'h77, 8'he1);
    rchk(8'h77, 8'h01);
    wr(8'h78, 8'h00);
    wr(8'h15, 8'h68);
    sfz(14'h0000, 14'h0000, 14'h3eff, 1'b1);
    rchk(8'h16, 8'hb0);
    sfz(14'h0000, 14'h0000, 14'h0100, 1'b0);
    wr(8'h73, 8'h00);
    wr(8'h18, 8'h03);
    rchk(8'h18, 8'h03);
    // hit, hit, miss, hit, hit: only the decrementing mode reaches three
    for (int m = 0; m < 2; m++) begin
      wr(8'h17, {m[0], 7'h10});
      repeat (3) sf(14'h0000, 14'h0000, 1'b0);
      for (int i = 0; i < 5; i++) begin
        sf(i == 2 ? 14'h0000 : 14'h0500, 14'h0000, i == 4 && m == 0);
      end
    end
    end_sim();
  end
endmodule
